// ===== rtl/host_port_pkg.sv
// shared constants and types of the dual channel host port
package host_port_pkg;

  // ==========================================================================
  // widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 6;
  localparam int NUM_CHAN = 2;
  localparam int NUM_REGS = 16;
  localparam int IDX_W = 4;
  localparam int LEVELS = 3;

  // ==========================================================================
  // per channel register indices
  localparam logic [IDX_W-1:0] REG_GLOBAL_EN = 4'h0;
  localparam logic [IDX_W-1:0] REG_FRAMER_STAT = 4'h1;
  localparam logic [IDX_W-1:0] REG_FRAMER_EN = 4'h2;
  localparam logic [IDX_W-1:0] REG_LIU_STAT = 4'h3;
  localparam logic [IDX_W-1:0] REG_LIU_EN = 4'h4;
  localparam logic [IDX_W-1:0] REG_BERT_STAT = 4'h5;
  localparam logic [IDX_W-1:0] REG_BERT_EN = 4'h6;
  localparam logic [IDX_W-1:0] REG_SUMMARY = 4'h7;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  // ==========================================================================
  // global enable and summary field positions
  localparam int LVL_FRAMER = 0;
  localparam int LVL_LIU = 1;
  localparam int LVL_BERT = 2;

  // ==========================================================================
  // serial mode pin roles and control byte layout
  localparam int PIN_MISO = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_SCLK = 2;
  localparam int PIN_SWAP = 5;
  localparam int PIN_CPHA = 6;
  localparam int PIN_CPOL = 7;
  localparam int CTL_RW_BIT = 7;
  localparam int CTL_BURST_BIT = 0;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [1:0] SETTLE_DONE = 2'h3;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [DATA_W-1:0] framer;
    logic [DATA_W-1:0] liu;
    logic [DATA_W-1:0] bert;
  } chan_events_t;

  typedef struct packed {
    logic write;
    logic chan;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } reg_req_t;

  typedef struct packed {
    logic hard_reset_n;
    logic host_sel;
    logic style;
    logic cs_a_n;
    logic cs_b_n;
    logic rds_n;
    logic wrd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pins_t;

  localparam pins_t PINS_IDLE = '{hard_reset_n: 1'b1, host_sel: 1'b0, style: 1'b0,
                                  cs_a_n: 1'b1, cs_b_n: 1'b1, rds_n: 1'b1, wrd: 1'b1,
                                  addr: 6'h00, data: 8'h00};

endpackage : host_port_pkg

// ===== rtl/dual_channel_host_port.sv
// host access port of a dual channel line transceiver
`timescale 1ns/1ns

// Contract
// RULE1: data pins undriven unless qualified read
// RULE2: host never asserts both selects
// RULE3: select a reaches channel one, b two
// RULE4: strobes ignored without one chip select
// RULE5: drive addressed register while read held
// RULE6: write captured at strobe rising edge
// RULE7: host select picks parallel or serial
// RULE8: serial clock d2, input d1, output d0
// RULE9: unmasked event pulls interrupt low
// RULE10: interrupt released once all serviced
// RULE11: global, framer, line, tester masks
// RULE12: style pin sets strobe pin meaning
// RULE13: hard reset clears whole device; serial frame state and serial output clear only on frame idle
// RULE14: d7 d6 give clock polarity, phase
// RULE15: d5 selects msb or lsb first
// RULE16: swap never moves direction, burst bits
// RULE17: direction high reads, low writes
// RULE18: select frames serial; output idle undriven
module dual_channel_host_port (
  // core clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // serial link clock, data pin 2 in serial mode
  input wire logic serial_clk_i,
  // host pins
  input wire logic hard_reset_n_i,
  input wire logic host_select_i,
  input wire logic strobe_style_select_i,
  input wire logic chan_a_select_n_i,
  input wire logic chan_b_select_n_i,
  input wire logic read_or_data_strobe_n_i,
  input wire logic write_or_direction_strobe_i,
  input wire logic [host_port_pkg::ADDR_W-1:0] addr_i,
  input wire logic [host_port_pkg::DATA_W-1:0] data_i,
  // parallel data drive
  output logic [host_port_pkg::DATA_W-1:0] data_o,
  output logic [host_port_pkg::DATA_W-1:0] data_oe_o,
  // serial data drive
  output logic miso_o,
  output logic miso_oe_o,
  // open drain interrupt
  output logic irq_out_n_o,
  output logic irq_oe_o,
  // channel events
  input host_port_pkg::chan_events_t events_i [host_port_pkg::NUM_CHAN]
);
  import host_port_pkg::*;

  // ==========================================================================
  // pin synchronisers
  pins_t pin_raw;
  pins_t pin_meta;
  pins_t pin_sync;
  pins_t pin_prev;

  assign pin_raw = {hard_reset_n_i, host_select_i, strobe_style_select_i,
                    chan_a_select_n_i, chan_b_select_n_i, read_or_data_strobe_n_i,
                    write_or_direction_strobe_i, addr_i, data_i};

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pin_meta <= PINS_IDLE;
      pin_sync <= PINS_IDLE;
      pin_prev <= PINS_IDLE;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  wire core_rst = srst_i | ~pin_sync.hard_reset_n; // [RULE13]

  // ==========================================================================
  // parallel decode
  wire par_mode = ~pin_sync.host_sel; // [RULE7]
  wire one_sel = pin_sync.cs_a_n ^ pin_sync.cs_b_n; // [RULE4]
  wire one_sel_prev = pin_prev.cs_a_n ^ pin_prev.cs_b_n;
  wire par_chan = pin_sync.cs_a_n; // [RULE3]
  wire rd_style_ds = ~pin_sync.rds_n & pin_sync.wrd; // [RULE17]
  wire rd_now = pin_sync.style ? rd_style_ds : ~pin_sync.rds_n; // [RULE12]
  wire par_read = par_mode & one_sel & rd_now; // [RULE5]
  wire ds_rise = pin_prev.rds_n == 1'b0 && pin_sync.rds_n == 1'b1 && !pin_prev.wrd; // [RULE17]
  wire wr_rise = !pin_prev.wrd && pin_sync.wrd;
  wire wr_edge = pin_prev.style ? ds_rise : wr_rise; // [RULE12]
  wire par_wr_commit = par_mode & one_sel_prev & wr_edge; // [RULE6]
  reg_req_t par_wreq;
  assign par_wreq = '{write: 1'b1, chan: pin_prev.cs_a_n, addr: pin_prev.addr,
                      data: pin_prev.data};

  // ==========================================================================
  // serial request crossing
  reg_req_t ser_req;
  logic ser_tog;
  logic tog_meta;
  logic tog_sync;
  logic tog_prev;
  logic [1:0] settle;
  logic [DATA_W-1:0] ser_rdata;

  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_prev <= 1'b0;
      settle <= 2'h0;
    end else begin
      tog_meta <= ser_tog;
      tog_sync <= tog_meta;
      tog_prev <= tog_sync;
      settle <= (settle == SETTLE_DONE) ? settle : settle + 2'h1;
    end
  end

  wire ser_take = (tog_sync ^ tog_prev) & (settle == SETTLE_DONE) & ~par_mode; // [RULE7]
  wire ser_wr = ser_take & ser_req.write;
  wire ser_rd = ser_take & ~ser_req.write;

  // ==========================================================================
  // register file
  logic [DATA_W-1:0] regs [NUM_CHAN][NUM_REGS];
  logic [DATA_W-1:0] next_regs [NUM_CHAN][NUM_REGS];
  logic [LEVELS-1:0] level_pend [NUM_CHAN];
  logic [NUM_CHAN-1:0] chan_pend;
  wire wr_en = par_wr_commit | ser_wr;
  reg_req_t wreq;
  assign wreq = par_wr_commit ? par_wreq : ser_req;

  function automatic logic is_status(input logic [IDX_W-1:0] idx);
    is_status = idx == REG_FRAMER_STAT || idx == REG_LIU_STAT || idx == REG_BERT_STAT;
  endfunction : is_status

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_pend
    assign level_pend[c][LVL_FRAMER] = |(regs[c][REG_FRAMER_STAT] & regs[c][REG_FRAMER_EN]);
    assign level_pend[c][LVL_LIU] = |(regs[c][REG_LIU_STAT] & regs[c][REG_LIU_EN]);
    assign level_pend[c][LVL_BERT] = |(regs[c][REG_BERT_STAT] & regs[c][REG_BERT_EN]);
    assign chan_pend[c] = |(level_pend[c] & regs[c][REG_GLOBAL_EN][LEVELS-1:0]); // [RULE11]
  end

  always_comb begin
    next_regs = regs;
    for (int c = 0; c < NUM_CHAN; c++) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (wr_en && wreq.chan == c[0] && wreq.addr == ADDR_W'(i)) begin // [RULE3]
          if (is_status(IDX_W'(i))) begin
            next_regs[c][i] = regs[c][i] & ~wreq.data; // [RULE10]
          end else if (IDX_W'(i) != REG_SUMMARY) begin
            next_regs[c][i] = wreq.data; // [RULE6]
          end
        end
      end
      next_regs[c][REG_FRAMER_STAT] = next_regs[c][REG_FRAMER_STAT] | events_i[c].framer;
      next_regs[c][REG_LIU_STAT] = next_regs[c][REG_LIU_STAT] | events_i[c].liu;
      next_regs[c][REG_BERT_STAT] = next_regs[c][REG_BERT_STAT] | events_i[c].bert;
      next_regs[c][REG_SUMMARY] = {5'h00, level_pend[c]};
    end
  end

  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      regs <= '{default: REG_RESET}; // [RULE13]
    end else begin
      regs <= next_regs;
    end
  end

  // ==========================================================================
  // read paths
  wire par_in_map = pin_sync.addr < ADDR_W'(NUM_REGS);
  wire [DATA_W-1:0] par_rdata = par_in_map ? regs[par_chan][pin_sync.addr[IDX_W-1:0]] : '0;
  wire ser_in_map = ser_req.addr < ADDR_W'(NUM_REGS);
  wire [DATA_W-1:0] ser_lookup = ser_in_map ? regs[ser_req.chan][ser_req.addr[IDX_W-1:0]] : '0;

  // ==========================================================================
  // core outputs
  always_ff @(posedge clock_i) begin
    if (core_rst) begin
      data_o <= '0;
      data_oe_o <= '0; // [RULE1]
      ser_rdata <= '0;
      irq_out_n_o <= 1'b1;
      irq_oe_o <= 1'b0;
    end else begin
      data_o <= par_rdata; // [RULE5]
      data_oe_o <= {DATA_W{par_read}}; // [RULE1]
      ser_rdata <= ser_rd ? ser_lookup : ser_rdata;
      irq_out_n_o <= ~|chan_pend; // [RULE9]
      irq_oe_o <= |chan_pend; // [RULE10]
    end
  end

  // ==========================================================================
  // serial link decode
  wire sclk_eff = serial_clk_i ^ data_i[PIN_CPOL] ^ data_i[PIN_CPHA]; // [RULE14]
  wire frame_idle = (chan_a_select_n_i & chan_b_select_n_i) | ~host_select_i; // [RULE18]
  wire mosi = data_i[PIN_MOSI]; // [RULE8]
  logic [2:0] bit_cnt;
  logic ctl_done;
  logic first_data;
  logic rw;
  logic burst;
  logic load_pend;
  logic swap_meta;
  logic swap_sync;
  logic [ADDR_W-1:0] cur_addr;
  logic [DATA_W-2:0] shift_in;
  logic [DATA_W-1:0] out_sr;

  wire [DATA_W-1:0] byte_val = {shift_in, mosi};
  wire byte_end = bit_cnt == BYTE_LAST;
  wire ctl_byte = byte_end & ~ctl_done;
  wire [ADDR_W-1:0] addr_field = byte_val[CTL_RW_BIT-1:CTL_BURST_BIT+1];
  wire [ADDR_W-1:0] addr_swapped = {<<{addr_field}};
  wire [ADDR_W-1:0] ctl_addr = swap_sync ? addr_swapped : addr_field; // [RULE16]
  wire [DATA_W-1:0] data_swapped = {<<{byte_val}};
  wire [DATA_W-1:0] data_val = swap_sync ? data_swapped : byte_val; // [RULE15]
  wire ctl_read = ctl_byte & byte_val[CTL_RW_BIT];
  wire data_go = byte_end & ctl_done & (rw ? burst : (burst | first_data));
  wire issue = ctl_read | data_go;
  reg_req_t next_req;
  assign next_req = ctl_byte ? '{write: 1'b0, chan: chan_a_select_n_i, addr: ctl_addr,
                                 data: 8'h00}
                  : rw ? '{write: 1'b0, chan: chan_a_select_n_i, addr: cur_addr + 6'h01,
                           data: 8'h00}
                  : '{write: 1'b1, chan: chan_a_select_n_i, addr: cur_addr, data: data_val};
  wire [DATA_W-1:0] rdata_swapped = {<<{ser_rdata}};
  wire [DATA_W-1:0] rdata_ordered = swap_sync ? rdata_swapped : ser_rdata; // [RULE15]

  // ==========================================================================
  // serial frame state, cleared whenever no select is low
  always_ff @(posedge sclk_eff or posedge frame_idle) begin
    if (frame_idle) begin
      bit_cnt <= 3'h0; // [RULE18]
      ctl_done <= 1'b0;
      first_data <= 1'b0;
      rw <= 1'b0;
      burst <= 1'b0;
      load_pend <= 1'b0;
      swap_meta <= 1'b0;
      swap_sync <= 1'b0;
      cur_addr <= '0;
      shift_in <= '0;
    end else begin
      swap_meta <= data_i[PIN_SWAP];
      swap_sync <= swap_meta;
      bit_cnt <= bit_cnt + 3'h1;
      shift_in <= byte_val[DATA_W-2:0];
      load_pend <= issue & ~next_req.write;
      if (ctl_byte) begin
        ctl_done <= 1'b1;
        rw <= byte_val[CTL_RW_BIT]; // [RULE16]
        burst <= byte_val[CTL_BURST_BIT];
        cur_addr <= ctl_addr;
        first_data <= 1'b1;
      end else if (byte_end) begin
        first_data <= 1'b0;
        cur_addr <= cur_addr + 6'h01;
      end
    end
  end

  // ==========================================================================
  // serial request hand-off, outlives the frame
  always_ff @(posedge sclk_eff or negedge hard_reset_n_i) begin
    if (!hard_reset_n_i) begin
      ser_req <= '0; // [RULE13]
      ser_tog <= 1'b0;
    end else if (issue) begin
      ser_req <= next_req;
      ser_tog <= ~ser_tog;
    end
  end

  // ==========================================================================
  // serial data out, changed on the launching edge
  always_ff @(negedge sclk_eff or posedge frame_idle) begin
    if (frame_idle) begin
      out_sr <= '0;
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0; // [RULE18]
    end else begin
      miso_oe_o <= ctl_done & rw; // [RULE8]
      if (load_pend) begin
        miso_o <= rdata_ordered[DATA_W-1];
        out_sr <= {rdata_ordered[DATA_W-2:0], 1'b0};
      end else begin
        miso_o <= out_sr[DATA_W-1];
        out_sr <= {out_sr[DATA_W-2:0], 1'b0};
      end
    end
  end

endmodule : dual_channel_host_port

// ===== dv/host_port_chk.sv
// pin checker of the dual channel host port
`timescale 1ns/1ns
module host_port_chk (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // host pins
  input wire logic hard_reset_n_i,
  input wire logic host_select_i,
  input wire logic chan_a_select_n_i,
  input wire logic chan_b_select_n_i,
  input wire logic read_or_data_strobe_n_i,
  // outputs
  input wire logic [host_port_pkg::DATA_W-1:0] data_oe_o,
  input wire logic miso_oe_o,
  input wire logic irq_out_n_o,
  input wire logic irq_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  wire logic idle = chan_a_select_n_i && chan_b_select_n_i;
  a_idle_undriven: assert property (idle [*5] |-> data_oe_o == '0)
    else $error("data pins driven with no select");
  a_oe_whole: assert property (data_oe_o == '0 || data_oe_o == '1)
    else $error("data pins partly driven");
  a_oe_cause: assert property ($rose(data_oe_o[0]) |->
    $past(!read_or_data_strobe_n_i, 2) && $past(chan_a_select_n_i != chan_b_select_n_i, 2)
    && $past(!host_select_i, 2)) else $error("data driven without qualified read");
  a_read_release: assert property ($rose(read_or_data_strobe_n_i) |->
    ##[1:5] data_oe_o == '0) else $error("data held after read strobe");
  a_serial_quiet: assert property (host_select_i [*5] |-> data_oe_o == '0)
    else $error("parallel drive in serial mode");
  a_par_no_miso: assert property (!host_select_i |-> !miso_oe_o)
    else $error("serial output driven in parallel mode");
  a_miso_framed: assert property (idle |-> !miso_oe_o)
    else $error("serial output driven outside frame");
  a_irq_drain: assert property (irq_oe_o != irq_out_n_o)
    else $error("interrupt enable and level disagree");
  a_hard_clear: assert property (!hard_reset_n_i [*5] |->
    irq_out_n_o && !irq_oe_o && data_oe_o == '0) else $error("hard reset not applied");
endmodule : host_port_chk

bind dual_channel_host_port host_port_chk host_port_chk_i (.clock_i, .srst_i,
  .hard_reset_n_i, .host_select_i, .chan_a_select_n_i, .chan_b_select_n_i,
  .read_or_data_strobe_n_i, .data_oe_o, .miso_oe_o, .irq_out_n_o, .irq_oe_o);

// ===== dv/host_model.sv
// host processor model driving the port pins
`timescale 1ns/1ns
module host_model (
  // clock
  input wire logic clock_i,
  // pad levels
  input wire logic [host_port_pkg::DATA_W-1:0] pad_i,
  // host drive
  output host_port_pkg::pins_t pins_o,
  output logic [host_port_pkg::DATA_W-1:0] drive_o
);
  import host_port_pkg::*;
  initial begin
    pins_o = PINS_IDLE;
    drive_o = '0;
  end
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      rev8[i] = v[7 - i];
  endfunction : rev8
  task automatic set_mode(input logic sel, input logic style);
    @(posedge clock_i);
    pins_o.host_sel <= sel;
    pins_o.style <= style;
    repeat (4) @(posedge clock_i);
  endtask : set_mode
  task automatic hard_reset();
    @(posedge clock_i);
    pins_o.hard_reset_n <= 1'b0;
    repeat (5) @(posedge clock_i);
    pins_o.hard_reset_n <= 1'b1;
    repeat (6) @(posedge clock_i);
  endtask : hard_reset
  // one parallel access, sel_n is {b, a}
  task automatic access(input logic [1:0] sel_n, input logic wr, input logic [5:0] addr,
                        input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clock_i);
    {pins_o.cs_b_n, pins_o.cs_a_n} <= sel_n;
    pins_o.addr <= addr;
    pins_o.data <= wd;
    drive_o <= {8{wr}};
    pins_o.wrd <= !(pins_o.style && wr);
    @(posedge clock_i);
    if (wr && !pins_o.style) pins_o.wrd <= 1'b0;
    else pins_o.rds_n <= 1'b0;
    repeat (6) @(posedge clock_i);
    rd = pad_i;
    pins_o.rds_n <= 1'b1;
    if (!pins_o.style) pins_o.wrd <= 1'b1;
    repeat (3) @(posedge clock_i);
    {pins_o.cs_b_n, pins_o.cs_a_n} <= 2'b11;
    pins_o.wrd <= 1'b1;
    drive_o <= '0;
    repeat (6) @(posedge clock_i);
  endtask : access
  // one serial frame, control byte then one data byte
  task automatic spi(input logic [1:0] sel_n, input logic rw, input logic [5:0] addr,
                     input logic [7:0] wd, input logic swap, output logic [7:0] rd);
    logic [15:0] sh;
    logic [7:0] ra;
    logic [7:0] rx;
    ra = rev8({addr, 2'b00});
    sh = {rw, swap ? ra[5:0] : addr, 1'b0, swap ? rev8(wd) : wd};
    rx = '0;
    @(posedge clock_i);
    pins_o.data <= {2'b00, swap, 3'b000, sh[15], 1'b0};
    drive_o <= 8'hFE;
    @(posedge clock_i);
    {pins_o.cs_b_n, pins_o.cs_a_n} <= sel_n;
    #37;
    for (int i = 0; i < 16; i++) begin
      #62 pins_o.data[PIN_SCLK] = 1'b1;
      rx = {rx[6:0], pad_i[PIN_MISO]};
      #63 pins_o.data[PIN_SCLK] = 1'b0;
      sh = sh << 1;
      pins_o.data[PIN_MOSI] = sh[15];
    end
    #60 {pins_o.cs_b_n, pins_o.cs_a_n} = 2'b11;
    @(posedge clock_i);
    drive_o <= '0;
    repeat (8) @(posedge clock_i);
    rd = swap ? rev8(rx) : rx;
  endtask : spi
endmodule : host_model

// ===== dv/tb.sv
// self checking bench of the dual channel host port
`timescale 1ns/1ns
module tb;
  import host_port_pkg::*;
  localparam logic [1:0] SEL_A = 2'b10;
  localparam logic [1:0] SEL_B = 2'b01;
  logic clock_i;
  logic srst_i;
  chan_events_t events [NUM_CHAN];
  pins_t pins;
  logic [7:0] drive, data_o, data_oe_o, pad, lvl, v;
  logic miso_o, miso_oe_o, irq_out_n_o, irq_oe_o;
  int error_cnt, samples_checked;
  wire logic irq_pad = irq_oe_o ? irq_out_n_o : 1'b1;
  assign lvl = (data_oe_o & data_o) | (~data_oe_o & drive & pins.data)
             | (~data_oe_o & ~drive & ~pins.data);
  assign pad = {lvl[7:1], miso_oe_o ? miso_o : lvl[0]};
  dual_channel_host_port dual_channel_host_port_i (.clock_i, .srst_i,
    .serial_clk_i(pad[PIN_SCLK]), .hard_reset_n_i(pins.hard_reset_n),
    .host_select_i(pins.host_sel), .strobe_style_select_i(pins.style),
    .chan_a_select_n_i(pins.cs_a_n), .chan_b_select_n_i(pins.cs_b_n),
    .read_or_data_strobe_n_i(pins.rds_n), .write_or_direction_strobe_i(pins.wrd),
    .addr_i(pins.addr), .data_i(pad), .data_o, .data_oe_o, .miso_o, .miso_oe_o,
    .irq_out_n_o, .irq_oe_o, .events_i(events));
  host_model host_model_i (.clock_i, .pad_i(pad), .pins_o(pins), .drive_o(drive));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [1:0] sel_n, input logic [5:0] addr, input logic [7:0] d);
    host_model_i.access(sel_n, 1'b1, addr, d, v);
  endtask : wr
  task automatic rd_chk(input logic [1:0] sel_n, input logic [5:0] addr, input logic [7:0] e);
    host_model_i.access(sel_n, 1'b0, addr, 8'h00, v);
    check(v, e);
  endtask : rd_chk
  task automatic pulse(input logic [23:0] ev);
    @(posedge clock_i);
    events[0] <= chan_events_t'(ev);
    @(posedge clock_i);
    events[0] <= '0;
    repeat (4) @(posedge clock_i);
  endtask : pulse
  task automatic t_parallel();
    for (int s = 0; s < 2; s++) begin
      host_model_i.set_mode(1'b0, s[0]);
      wr(SEL_A, 6'h08, 8'h5A ^ s[7:0]);
      wr(SEL_B, 6'h08, 8'hA5 ^ s[7:0]);
      rd_chk(SEL_A, 6'h08, 8'h5A ^ s[7:0]);
      rd_chk(SEL_B, 6'h08, 8'hA5 ^ s[7:0]);
    end
  endtask : t_parallel
  task automatic t_refused();
    host_model_i.set_mode(1'b0, 1'b0);
    wr(2'b11, 6'h08, 8'h00);
    wr(2'b00, 6'h08, 8'h00);
    wr(SEL_A, 6'h20, 8'hFF);
    rd_chk(2'b11, 6'h08, 8'hFF);
    rd_chk(SEL_A, 6'h08, 8'h5B);
    rd_chk(SEL_B, 6'h08, 8'hA4);
    rd_chk(SEL_A, 6'h20, 8'h00);
  endtask : t_refused
  task automatic t_irq();
    wr(SEL_A, 6'h02, 8'h01);
    wr(SEL_A, 6'h04, 8'h00);
    wr(SEL_A, 6'h00, 8'h00);
    pulse(24'h010000);
    check(irq_pad, 1'b1);
    wr(SEL_A, 6'h00, 8'h07);
    check(irq_pad, 1'b0);
    rd_chk(SEL_A, 6'h07, 8'h01);
    wr(SEL_A, 6'h01, 8'h01);
    check(irq_pad, 1'b1);
    pulse(24'h000100);
    check(irq_pad, 1'b1);
    wr(SEL_A, 6'h03, 8'hFF);
  endtask : t_irq
  task automatic t_serial();
    host_model_i.set_mode(1'b1, 1'b0);
    host_model_i.spi(SEL_A, 1'b0, 6'h09, 8'h3C, 1'b1, v);
    host_model_i.spi(SEL_A, 1'b1, 6'h09, 8'h00, 1'b0, v);
    check(v, 8'h3C);
    host_model_i.spi(SEL_B, 1'b1, 6'h08, 8'h00, 1'b1, v);
    check(v, 8'hA4);
    host_model_i.set_mode(1'b0, 1'b0);
    rd_chk(SEL_A, 6'h09, 8'h3C);
  endtask : t_serial
  task automatic t_hard();
    host_model_i.hard_reset();
    rd_chk(SEL_A, 6'h09, 8'h00);
    rd_chk(SEL_B, 6'h08, 8'h00);
  endtask : t_hard
  initial begin
    srst_i = 1'b1;
    events = '{default: '0};
    error_cnt = 0;
    samples_checked = 0;
    repeat (12) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    t_parallel();
    t_refused();
    t_irq();
    t_serial();
    t_hard();
    complete_run();
  end
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
endmodule : tb
